// [rtl/burst_sram_pkg.sv]
package burst_sram_pkg;

    // word and address geometry
    localparam int ADDR_W = 16;
    localparam int DEPTH = 65536;
    localparam int DATA_W = 16;
    localparam int LANE_W = 9;
    localparam int WORD_W = 18;
    localparam int LANES = 2;
    localparam int BURST_W = 2;

    // field positions inside one stored word
    localparam int LANE0_LSB = 0;
    localparam int LANE1_LSB = 9;
    localparam int PARITY_POS = 8;
    localparam int BYTE_W = 8;

    // values after reset, full lane mask and burst step
    localparam logic [WORD_W-1:0] WORD_RST = 18'h00000;
    localparam logic [ADDR_W-1:0] ADDR_RST = 16'h0000;
    localparam logic [LANES-1:0] LANES_NONE = 2'h0;
    localparam logic [LANES-1:0] LANES_ALL = 2'h3;
    localparam logic [BURST_W-1:0] BURST_RST = 2'h0;
    localparam logic [BURST_W-1:0] BURST_STEP = 2'h1;

    // access state, gray coded along load, burst, wait
    typedef enum logic [1:0] {
        PWR_DOWN = 2'b00,
        FIRST = 2'b01,
        BURSTING = 2'b11,
        WAITING = 2'b10
    } mode_t;

endpackage

// [rtl/burst_counter.sv]
`timescale 1ns/1ps
// two-bit interleaved burst address generator
module burst_counter (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic load,
    input wire logic [burst_sram_pkg::BURST_W-1:0] startLow,
    input wire logic advance,
    output logic [burst_sram_pkg::BURST_W-1:0] curLow,
    output logic [burst_sram_pkg::BURST_W-1:0] nextLow
);

    logic [burst_sram_pkg::BURST_W-1:0] startQ; // low bits of loaded address
    logic [burst_sram_pkg::BURST_W-1:0] stepQ; // advances made since load
    logic [burst_sram_pkg::BURST_W-1:0] stepD; // step after an advance

    // two-bit step wraps to zero on the fourth advance
    assign stepD = stepQ + burst_sram_pkg::BURST_STEP;

    // interleaved order: start address xor step count
    assign curLow = startQ ^ stepQ;
    assign nextLow = startQ ^ stepD;

    // counter registers
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            startQ <= burst_sram_pkg::BURST_RST;
            stepQ <= burst_sram_pkg::BURST_RST;
        end else if (load) begin
            // new external address restarts the sequence
            startQ <= startLow;
            stepQ <= burst_sram_pkg::BURST_RST;
        end else if (advance) begin
            // step only on the low two bits
            stepQ <= stepD;
        end
    end

endmodule

// [rtl/pipelined_burst_sram_port.sv]
`timescale 1ns/1ps
// synchronous pipelined burst memory, 64K words of two parity lanes
module pipelined_burst_sram_port (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [burst_sram_pkg::ADDR_W-1:0] addrIn,
    input wire logic chipEnable_n,
    input wire logic procAddrStrobe_n,
    input wire logic ctrlAddrStrobe_n,
    input wire logic burstAdvance_n,
    input wire logic lowByteWrite_n,
    input wire logic highByteWrite_n,
    input wire logic outputEnable_n,
    input wire logic [burst_sram_pkg::DATA_W-1:0] dataIoIn,
    output logic [burst_sram_pkg::DATA_W-1:0] dataIoOut,
    output logic [burst_sram_pkg::LANES-1:0] dataIoOe,
    input wire logic lowParityIoIn,
    output logic lowParityIoOut,
    output logic lowParityIoOe,
    input wire logic highParityIoIn,
    output logic highParityIoOut,
    output logic highParityIoOe
);

    // merge new lanes into an old word under a lane mask
    function automatic logic [burst_sram_pkg::WORD_W-1:0] mergeLanes(
        input logic [burst_sram_pkg::WORD_W-1:0] oldWord,
        input logic [burst_sram_pkg::WORD_W-1:0] newWord,
        input logic [burst_sram_pkg::LANES-1:0] mask
    );
        logic [burst_sram_pkg::WORD_W-1:0] res;
        res = oldWord;
        if (mask[0]) begin
            res[burst_sram_pkg::LANE0_LSB +: burst_sram_pkg::LANE_W] =
                newWord[burst_sram_pkg::LANE0_LSB +: burst_sram_pkg::LANE_W];
        end
        if (mask[1]) begin
            res[burst_sram_pkg::LANE1_LSB +: burst_sram_pkg::LANE_W] =
                newWord[burst_sram_pkg::LANE1_LSB +: burst_sram_pkg::LANE_W];
        end
        return res;
    endfunction

    // storage array, two nine-bit lanes per word
    logic [burst_sram_pkg::WORD_W-1:0] memArray [burst_sram_pkg::DEPTH];

    // front-end state
    burst_sram_pkg::mode_t modeQ; // power-down, loaded, bursting, waiting
    burst_sram_pkg::mode_t modeD; // next access state
    logic [burst_sram_pkg::ADDR_W-1:0] baseQ; // registered external address

    // read pipeline
    logic [burst_sram_pkg::ADDR_W-1:0] rdAddrQ; // address of pending read
    logic readPendQ; // a read was registered at the last edge

    // pass-through tracking of the last write
    logic wrValidQ; // last edge performed a write
    logic [burst_sram_pkg::LANES-1:0] wrLanesQ; // lanes written at last edge
    logic [burst_sram_pkg::WORD_W-1:0] wrDataQ; // word written at last edge

    // output register and its drive state
    logic [burst_sram_pkg::WORD_W-1:0] outQ; // output data register
    logic [burst_sram_pkg::LANES-1:0] laneEnQ; // lanes holding valid output
    logic floatQ; // write strobe sampled low at last edge

    // decoded cycle type of this edge
    logic anyWrite; // at least one write strobe low
    logic procLoad; // processor strobe load
    logic ctrlLoad; // controller strobe load
    logic newLoad; // any external address load
    logic deselect; // enter power-down
    logic selected; // device out of power-down
    logic isWrite; // this access writes
    logic doAccess; // this edge accesses the array
    logic doWrite; // this edge writes the array
    logic advance; // burst counter steps this edge
    logic [burst_sram_pkg::LANES-1:0] wrMask; // lanes enabled by strobes
    logic [burst_sram_pkg::WORD_W-1:0] dataWord; // pins gathered into one word
    logic [burst_sram_pkg::ADDR_W-1:0] accessAddr; // address used this edge
    logic [burst_sram_pkg::BURST_W-1:0] curLow; // current burst low bits
    logic [burst_sram_pkg::BURST_W-1:0] nextLow; // next burst low bits

    // gather the pins into the stored word layout
    assign dataWord = {highParityIoIn,
                       dataIoIn[burst_sram_pkg::DATA_W-1:burst_sram_pkg::BYTE_W],
                       lowParityIoIn,
                       dataIoIn[burst_sram_pkg::BYTE_W-1:0]};

    // each strobe gates its own lane
    assign wrMask = {~highByteWrite_n, ~lowByteWrite_n};
    assign anyWrite = |wrMask;

    // processor strobe with chip selected loads and reads
    assign procLoad = ~procAddrStrobe_n & ~chipEnable_n;
    // controller strobe loads only while processor strobe is high
    assign ctrlLoad = procAddrStrobe_n & ~ctrlAddrStrobe_n & ~chipEnable_n;
    assign newLoad = procLoad | ctrlLoad;
    // controller strobe with chip deselected powers down
    assign deselect = ~ctrlAddrStrobe_n & chipEnable_n;
    assign selected = (modeQ != burst_sram_pkg::PWR_DOWN);

    // processor load never writes; otherwise any strobe low writes
    assign isWrite = anyWrite & ~procLoad;

    // continuation and suspension ignore chip select
    assign doAccess = newLoad | (~deselect & selected);
    assign doWrite = doAccess & isWrite;
    assign advance = ~newLoad & ~deselect & selected & ~burstAdvance_n;

    // first access external, later ones keep upper bits
    always_comb begin
        if (newLoad) begin
            accessAddr = addrIn;
        end else if (~burstAdvance_n) begin
            // next interleaved address
            accessAddr = {baseQ[burst_sram_pkg::ADDR_W-1:burst_sram_pkg::BURST_W], nextLow};
        end else begin
            // wait state repeats the current address
            accessAddr = {baseQ[burst_sram_pkg::ADDR_W-1:burst_sram_pkg::BURST_W], curLow};
        end
    end

    // low two bits come from the burst counter
    burst_counter u_burst_counter (
        .clk(clk),
        .sys_rst(sys_rst),
        .load(newLoad),
        .startLow(addrIn[burst_sram_pkg::BURST_W-1:0]),
        .advance(advance),
        .curLow(curLow),
        .nextLow(nextLow)
    );

    // next access state
    always_comb begin
        modeD = modeQ;
        case (modeQ)
            burst_sram_pkg::PWR_DOWN: begin
                // only a fresh load wakes the device
                if (newLoad) begin
                    modeD = burst_sram_pkg::FIRST;
                end
            end
            burst_sram_pkg::FIRST,
            burst_sram_pkg::BURSTING,
            burst_sram_pkg::WAITING: begin
                if (newLoad) begin
                    // any load aborts the running burst
                    modeD = burst_sram_pkg::FIRST;
                end else if (deselect) begin
                    modeD = burst_sram_pkg::PWR_DOWN;
                end else if (~burstAdvance_n) begin
                    modeD = burst_sram_pkg::BURSTING;
                end else begin
                    modeD = burst_sram_pkg::WAITING;
                end
            end
            default: begin
                modeD = burst_sram_pkg::PWR_DOWN;
            end
        endcase
    end

    // access state register, powered down from reset
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            modeQ <= burst_sram_pkg::PWR_DOWN;
        end else begin
            modeQ <= modeD;
        end
    end

    // registered external address
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            baseQ <= burst_sram_pkg::ADDR_RST;
        end else if (newLoad) begin
            // upper bits held for the whole burst
            baseQ <= addrIn;
        end
    end

    // array write, unstrobed lanes keep their contents
    always_ff @(posedge clk) begin
        if (doWrite) begin
            memArray[accessAddr] <= mergeLanes(memArray[accessAddr], dataWord, wrMask);
        end
    end

    // read pipeline, address stage
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdAddrQ <= burst_sram_pkg::ADDR_RST;
            readPendQ <= 1'b0;
        end else begin
            // processor load always reads at its edge
            readPendQ <= doAccess & ~isWrite;
            if (doAccess) begin
                rdAddrQ <= accessAddr;
            end
        end
    end

    // remember the last write for pass-through
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wrValidQ <= 1'b0;
            wrLanesQ <= burst_sram_pkg::LANES_NONE;
            wrDataQ <= burst_sram_pkg::WORD_RST;
        end else begin
            wrValidQ <= doWrite;
            wrLanesQ <= wrMask;
            wrDataQ <= dataWord;
        end
    end

    // output register, one edge behind the address
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            outQ <= burst_sram_pkg::WORD_RST;
            laneEnQ <= burst_sram_pkg::LANES_NONE;
            floatQ <= 1'b1;
        end else begin
            // a strobe low sampled here floats the pins next cycle
            floatQ <= anyWrite;
            if (wrValidQ & ~anyWrite) begin
                // written lanes pass straight to the output, once only
                outQ <= mergeLanes(outQ, wrDataQ, wrLanesQ);
                laneEnQ <= wrLanesQ;
            end else if (readPendQ) begin
                // pipelined read data from the registered address
                outQ <= memArray[rdAddrQ];
                laneEnQ <= burst_sram_pkg::LANES_ALL;
            end else begin
                // nothing valid, nothing carries over
                laneEnQ <= burst_sram_pkg::LANES_NONE;
            end
        end
    end

    // data pins straight from the output register
    assign dataIoOut = {outQ[burst_sram_pkg::LANE1_LSB +: burst_sram_pkg::BYTE_W],
                        outQ[burst_sram_pkg::LANE0_LSB +: burst_sram_pkg::BYTE_W]};
    assign lowParityIoOut = outQ[burst_sram_pkg::LANE0_LSB + burst_sram_pkg::PARITY_POS];
    assign highParityIoOut = outQ[burst_sram_pkg::LANE1_LSB + burst_sram_pkg::PARITY_POS];

    // drivers gated asynchronously by output enable
    assign dataIoOe = laneEnQ & {burst_sram_pkg::LANES{~floatQ & ~outputEnable_n}};
    assign lowParityIoOe = laneEnQ[0] & ~floatQ & ~outputEnable_n;
    assign highParityIoOe = laneEnQ[1] & ~floatQ & ~outputEnable_n;

endmodule

// [testbench/sram_port_assertions.sv]
`timescale 1ns/1ps
// port-level checks of the burst memory port
module sram_port_assertions (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [burst_sram_pkg::ADDR_W-1:0] addrIn,
    input wire logic chipEnable_n,
    input wire logic procAddrStrobe_n,
    input wire logic ctrlAddrStrobe_n,
    input wire logic burstAdvance_n,
    input wire logic lowByteWrite_n,
    input wire logic highByteWrite_n,
    input wire logic outputEnable_n,
    input wire logic [burst_sram_pkg::DATA_W-1:0] dataIoIn,
    input wire logic [burst_sram_pkg::DATA_W-1:0] dataIoOut,
    input wire logic [burst_sram_pkg::LANES-1:0] dataIoOe,
    input wire logic lowParityIoIn,
    input wire logic lowParityIoOut,
    input wire logic lowParityIoOe,
    input wire logic highParityIoIn,
    input wire logic highParityIoOut,
    input wire logic highParityIoOe
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // decoded bus cycle kinds
    wire wrAny = !lowByteWrite_n || !highByteWrite_n;
    wire rdOnly = lowByteWrite_n && highByteWrite_n;
    wire procLd = !procAddrStrobe_n && !chipEnable_n;
    wire ctrlLd = procAddrStrobe_n && !ctrlAddrStrobe_n && !chipEnable_n;
    wire noLoad = !procLd && !ctrlLd;
    a_write_floats_bus: assert property (wrAny && procAddrStrobe_n |=> dataIoOe == 2'h0)
        else $error("lanes driven after a write edge");
    a_oe_async_float: assert property (outputEnable_n |-> dataIoOe == 2'h0 && !highParityIoOe)
        else $error("lanes driven with output enable high");
    a_parity_lane_pair: assert property (lowParityIoOe == dataIoOe[0] && highParityIoOe == dataIoOe[1])
        else $error("parity enable differs from its lane");
    a_desel_stays_off: assert property (!ctrlAddrStrobe_n && chipEnable_n ##1 noLoad |=> dataIoOe == 2'h0)
        else $error("lanes driven while powered down");
    a_proc_read_drives: assert property (procLd ##1 rdOnly && ctrlAddrStrobe_n |=> outputEnable_n || dataIoOe == 2'h3)
        else $error("read data not driven one cycle after load");
    a_pass_full_word: assert property (ctrlLd && !lowByteWrite_n && !highByteWrite_n ##1 rdOnly
        |=> dataIoOut == $past(dataIoIn, 2) && lowParityIoOut == $past(lowParityIoIn, 2))
        else $error("written word not passed through");
    a_pass_one_lane: assert property (ctrlLd && !lowByteWrite_n && highByteWrite_n ##1 rdOnly
        |=> outputEnable_n || dataIoOe == 2'h1)
        else $error("one-byte pass-through drives wrong lanes");
    a_suspend_repeat: assert property (procLd ##1 (rdOnly && noLoad && burstAdvance_n) [*2] |=> $stable(dataIoOut))
        else $error("wait state changed read data");
    c_proc_read: cover property (procLd ##1 rdOnly);
    c_ctrl_write: cover property (ctrlLd && wrAny);
    c_deselect: cover property (!ctrlAddrStrobe_n && chipEnable_n);
endmodule

// [testbench/cache_ctrl_model.sv]
`timescale 1ns/1ps
// cache controller side of the memory bus
module cache_ctrl_model (
    input wire logic clk,
    output logic [burst_sram_pkg::ADDR_W-1:0] addrIn,
    output logic chipEnable_n,
    output logic procAddrStrobe_n,
    output logic ctrlAddrStrobe_n,
    output logic burstAdvance_n,
    output logic lowByteWrite_n,
    output logic highByteWrite_n,
    output logic outputEnable_n,
    output logic [burst_sram_pkg::WORD_W-1:0] busWord
);
    logic oeOff = 1'b0; // bench-forced output disable
    logic [17:0] lastW = 18'h00000; // last word driven onto the bus for a write
    // idle bus at time zero
    initial begin
        {procAddrStrobe_n, ctrlAddrStrobe_n, burstAdvance_n, chipEnable_n} = 4'hF;
        {highByteWrite_n, lowByteWrite_n} = 2'h3;
        addrIn = 16'h0000;
        busWord = 18'h3FFFF;
    end
    // enable lifted whenever a write is on the bus
    assign outputEnable_n = oeOff | ~(lowByteWrite_n & highByteWrite_n);
    // one bus cycle: drive after an edge, hold through the next edge
    task automatic cyc(input logic p, c, v, e, input logic [1:0] we, input logic [15:0] a, input logic [17:0] w);
        procAddrStrobe_n = p;
        ctrlAddrStrobe_n = c;
        burstAdvance_n = v;
        chipEnable_n = e;
        {highByteWrite_n, lowByteWrite_n} = we;
        addrIn = a;
        if (we != 2'h3) lastW = w;
        // released bus never shows the stale word
        busWord = (we != 2'h3) ? w : ~lastW;
        @(posedge clk);
        #1;
    endtask
endmodule

// [testbench/tb_top.sv]
`timescale 1ns/1ps
// self-checking bench for the burst memory port
module tb_top;
    localparam logic [15:0] ADR_A = 16'h5A71;
    localparam logic [15:0] ADR_B = 16'h1234;
    localparam logic [15:0] ADR_C = 16'h8766;
    localparam logic [17:0] W1 = 18'h12345;
    localparam logic [17:0] W2 = 18'h2ABCD;
    localparam logic [17:0] W3 = 18'h0F0F0;
    localparam logic [17:0] MIX = {W1[17:9], W2[8:0]};
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [burst_sram_pkg::ADDR_W-1:0] addrIn;
    logic chipEnable_n, procAddrStrobe_n, ctrlAddrStrobe_n, burstAdvance_n;
    logic lowByteWrite_n, highByteWrite_n, outputEnable_n;
    logic [burst_sram_pkg::DATA_W-1:0] dataIoIn, dataIoOut;
    logic [burst_sram_pkg::LANES-1:0] dataIoOe;
    logic lowParityIoIn, lowParityIoOut, lowParityIoOe;
    logic highParityIoIn, highParityIoOut, highParityIoOe;
    logic [burst_sram_pkg::WORD_W-1:0] busWord;
    logic [17:0] wd [4] = '{18'h3FF00, 18'h00FF1, 18'h2A5A5, 18'h15A5A};
    int failures = 0;
    int checksDone = 0;
    pipelined_burst_sram_port u_dut (.*);
    cache_ctrl_model u_ctrl (.*);
    // wire level per lane from both drivers
    assign dataIoIn[7:0] = dataIoOe[0] ? dataIoOut[7:0] : busWord[7:0];
    assign dataIoIn[15:8] = dataIoOe[1] ? dataIoOut[15:8] : busWord[16:9];
    assign lowParityIoIn = lowParityIoOe ? lowParityIoOut : busWord[8];
    assign highParityIoIn = highParityIoOe ? highParityIoOut : busWord[17];
    initial forever #5 clk = ~clk;
    // compare lane enables and the driven lanes
    task automatic chk(input logic [1:0] oe, input logic [17:0] w);
        logic [17:0] got;
        got = {highParityIoOut, dataIoOut[15:8], lowParityIoOut, dataIoOut[7:0]};
        checksDone++;
        if ({highParityIoOe, dataIoOe, lowParityIoOe} !== {oe[1], oe, oe[0]}
            || (oe[0] && got[8:0] !== w[8:0]) || (oe[1] && got[17:9] !== w[17:9])) begin
            failures++;
            $display("MISMATCH %0t lanes %b word %h", $time, dataIoOe, got);
        end
    endtask
    // idle after reset: nothing driven
    task automatic t_power_up();
        chk(2'h0, 18'h00000);
        u_ctrl.cyc(1, 1, 0, 0, 2'h3, 16'h0000, 18'h00000);
        chk(2'h0, 18'h00000);
    endtask
    // four-word write burst, address pins ignored after the load
    task automatic t_burst_write();
        u_ctrl.cyc(1, 0, 1, 0, 2'h0, ADR_A, wd[0]);
        chk(2'h0, 18'h00000);
        for (int i = 1; i < 4; i++) begin
            u_ctrl.cyc(1, 1, 0, 1, 2'h0, 16'hFFFF, wd[i]);
            chk(2'h0, 18'h00000);
        end
    endtask
    // read burst from another start, with a wait state and a wrap
    task automatic t_burst_read();
        int seq [5] = '{1, 2, 2, 3, 0};
        int prev;
        prev = 0;
        u_ctrl.cyc(0, 1, 1, 0, 2'h0, ADR_A ^ 16'h0003, 18'h00000);
        for (int k = 0; k < 5; k++) begin
            u_ctrl.cyc(1, 1, k == 2, 1, 2'h3, 16'h0000, 18'h00000);
            chk(2'h3, wd[3 ^ prev]);
            prev = seq[k];
        end
        u_ctrl.cyc(1, 1, 1, 1, 2'h3, 16'h0000, 18'h00000);
        chk(2'h3, wd[3 ^ prev]);
    endtask
    // lanes, pass-through and write after a processor load
    task automatic t_lanes();
        u_ctrl.cyc(1, 0, 1, 0, 2'h0, ADR_B, W1);
        chk(2'h0, 18'h00000);
        u_ctrl.cyc(1, 1, 1, 1, 2'h3, 16'h0000, 18'h00000);
        chk(2'h3, W1);
        u_ctrl.cyc(1, 0, 1, 0, 2'h2, ADR_B, W2);
        chk(2'h0, 18'h00000);
        u_ctrl.cyc(1, 1, 1, 1, 2'h3, 16'h0000, 18'h00000);
        chk(2'h1, W2);
        u_ctrl.cyc(0, 1, 1, 0, 2'h3, ADR_C, 18'h00000);
        chk(2'h3, MIX);
        u_ctrl.cyc(1, 1, 1, 1, 2'h0, 16'h0000, W3);
        chk(2'h0, 18'h00000);
        u_ctrl.cyc(1, 0, 1, 0, 2'h3, ADR_B, 18'h00000);
        chk(2'h3, W3);
        u_ctrl.cyc(1, 1, 1, 1, 2'h3, 16'h0000, 18'h00000);
        chk(2'h3, MIX);
        u_ctrl.cyc(0, 1, 1, 0, 2'h3, ADR_C, 18'h00000);
        chk(2'h3, MIX);
        u_ctrl.cyc(1, 1, 1, 1, 2'h3, 16'h0000, 18'h00000);
        chk(2'h3, W3);
        u_ctrl.cyc(1, 1, 1, 1, 2'h3, 16'h0000, 18'h00000);
        chk(2'h3, W3);
    endtask
    // power-down, then asynchronous output enable
    task automatic t_desel_oe();
        u_ctrl.cyc(1, 0, 0, 1, 2'h3, 16'h0000, 18'h00000);
        u_ctrl.cyc(1, 1, 0, 0, 2'h3, 16'h0000, 18'h00000);
        chk(2'h0, 18'h00000);
        u_ctrl.cyc(1, 0, 1, 0, 2'h3, ADR_B, 18'h00000);
        chk(2'h0, 18'h00000);
        u_ctrl.cyc(1, 1, 1, 1, 2'h3, 16'h0000, 18'h00000);
        chk(2'h3, MIX);
        u_ctrl.oeOff = 1'b1;
        #1;
        chk(2'h0, 18'h00000);
        u_ctrl.oeOff = 1'b0;
        #1;
        chk(2'h3, MIX);
    endtask
    // verdict and end of run
    task automatic finish_test();
        if (failures == 0 && checksDone > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (16) @(posedge clk);
        #1;
        sys_rst = 1'b0;
        t_power_up();
        t_burst_write();
        t_burst_read();
        t_lanes();
        t_desel_oe();
        finish_test();
    end
    // watchdog
    initial begin
        #5000;
        failures++;
        finish_test();
    end
endmodule
bind pipelined_burst_sram_port sram_port_assertions u_chk (.*);
